// >>> src/rsm_pkg.sv
// Shared constants for the receiver status and error monitor.
// Assumes a single 250 MHz clock and a plain address/strobe register port.
package rsm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port geometry and register byte addresses.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_ERROR_WORD = 8'h00;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h04;
  localparam logic [7:0] OFS_PRIO_MASK = 8'h08;
  localparam logic [7:0] OFS_SET_MASK = 8'h0C;
  localparam logic [7:0] OFS_CLEAR_MASK = 8'h10;
  localparam logic [7:0] OFS_AUX1_STATUS = 8'h14;
  localparam logic [7:0] OFS_AUX2_STATUS = 8'h18;
  localparam logic [7:0] OFS_AUX3_STATUS = 8'h1C;
  localparam logic [7:0] OFS_AUX1_PRIO = 8'h20;
  localparam logic [7:0] OFS_AUX2_PRIO = 8'h24;
  localparam logic [7:0] OFS_AUX3_PRIO = 8'h28;
  localparam logic [7:0] OFS_CONTROL = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int STAT_ERROR_BIT = 0;
  localparam int STAT_AUX1_BIT = 31;
  localparam int STAT_AUX2_BIT = 30;
  localparam int STAT_AUX3_BIT = 29;
  localparam int CTRL_EVENT_EN_BIT = 0;
  localparam int CTRL_ERROR_STATE_BIT = 1;
  localparam int IRQ_ERROR_BIT = 0;
  localparam int IRQ_RISE_BIT = 1;
  localparam int IRQ_FALL_BIT = 2;
  localparam int IRQ_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic CTRL_EVENT_EN_RESET = 1'b1;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one quarter second is the base tick of the indicator.
  localparam int CLK_MHZ = 250;
  localparam int QUARTER_MS = 250;
  localparam int QUARTER_CYC = QUARTER_MS * 1000 * CLK_MHZ;
  localparam int FLASH_ON_MS = 500;
  localparam int FLASH_OFF_MS = 250;
  localparam int PAUSE_MS = 1000;
  localparam int GREEN_HALF_MS = 500;
  localparam logic [2:0] FLASH_ON_Q = 3'(FLASH_ON_MS / QUARTER_MS);
  localparam logic [2:0] FLASH_OFF_Q = 3'(FLASH_OFF_MS / QUARTER_MS);
  localparam logic [2:0] PAUSE_Q = 3'(PAUSE_MS / QUARTER_MS);
  localparam logic [2:0] GREEN_HALF_Q = 3'(GREEN_HALF_MS / QUARTER_MS);
  localparam logic [2:0] FLASH_COUNT = 3'h6;
  localparam int CODE_W = 6;

  // Phases of the error code sequence.
  typedef enum logic [1:0] {
    RSM_LED_ON,
    RSM_LED_OFF,
    RSM_LED_PAUSE
  } rsm_led_e;

endpackage : rsm_pkg

// >>> src/rsm_divider.sv
// Divider that turns the system clock into a one-cycle enable pulse.
// Assumes a synchronous active-high reset; DIV_CYC is at least 2.
module rsm_divider #(
  parameter int DIV_CYC = 62500000
) (
  input wire logic clock,
  input wire logic reset,
  output logic tick
);
  import rsm_pkg::*;

  logic [31:0] count_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Count up and pulse once per period.
  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (count_reg == 32'(DIV_CYC - 1)) begin
      count_reg <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

endmodule : rsm_divider

// >>> src/rsm_led.sv
// Status indicator sequencer: green blink when healthy, six-flash code on error.
// Assumes tick is a one-cycle pulse every quarter second.
module rsm_led (
  input wire logic clock,
  input wire logic reset,
  input wire logic tick,
  input wire logic error_state,
  input wire logic [rsm_pkg::CODE_W-1:0] code,
  output logic led_green,
  output logic led_red,
  output logic led_yellow
);
  import rsm_pkg::*;

  rsm_led_e phase_reg;
  logic [2:0] quarter_reg;
  logic [2:0] flash_reg;
  logic code_bit;

  // Flashes present the code most significant bit first: red for one, yellow for zero.
  assign code_bit = code[3'(CODE_W - 1) - flash_reg];

  ////////////////////////////////////////////////////////////////////////////
  // Green blink in normal operation, looping code sequence in the error state.
  always_ff @(posedge clock) begin
    if (reset) begin
      phase_reg <= RSM_LED_ON;
      quarter_reg <= 3'h0;
      flash_reg <= 3'h0;
      led_green <= 1'b0;
      led_red <= 1'b0;
      led_yellow <= 1'b0;
    end else if (!error_state) begin
      led_red <= 1'b0;
      led_yellow <= 1'b0;
      if (tick) begin
        if (quarter_reg == GREEN_HALF_Q - 3'h1) begin
          quarter_reg <= 3'h0;
          led_green <= !led_green;
        end else begin
          quarter_reg <= quarter_reg + 3'h1;
        end
      end
    end else begin
      led_green <= 1'b0;
      led_red <= (phase_reg == RSM_LED_ON) && code_bit;
      led_yellow <= (phase_reg == RSM_LED_ON) && !code_bit;
      if (tick) begin
        quarter_reg <= quarter_reg + 3'h1;
        case (phase_reg)
          RSM_LED_ON: begin
            if (quarter_reg == FLASH_ON_Q - 3'h1) begin
              quarter_reg <= 3'h0;
              phase_reg <= RSM_LED_OFF;
            end
          end
          RSM_LED_OFF: begin
            if (quarter_reg == FLASH_OFF_Q - 3'h1) begin
              quarter_reg <= 3'h0;
              if (flash_reg == FLASH_COUNT - 3'h1) begin
                flash_reg <= 3'h0;
                phase_reg <= RSM_LED_PAUSE;
              end else begin
                flash_reg <= flash_reg + 3'h1;
                phase_reg <= RSM_LED_ON;
              end
            end
          end
          default: begin
            if (quarter_reg == PAUSE_Q - 3'h1) begin
              quarter_reg <= 3'h0;
              phase_reg <= RSM_LED_ON;
            end
          end
        endcase
      end
    end
  end

endmodule : rsm_led

// >>> src/rsm_monitor.sv
// Receiver status and error monitor: error word, status word, masks, events,
// error latch, error pin, tracking shutdown and status indicator.
// Assumes condition inputs are synchronous levels and a single-cycle register port.
//
// The register offsets and the strobed register port were left to the implementer.
module rsm_monitor #(
  parameter int QUARTER_TICK_CYC = rsm_pkg::QUARTER_CYC
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [rsm_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [rsm_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [rsm_pkg::DATA_W-1:0] bus_rdata,
  input wire logic [31:0] fatal_cond,
  input wire logic [31:0] status_cond,
  input wire logic [31:0] aux1_cond,
  input wire logic [31:0] aux2_cond,
  input wire logic [31:0] aux3_cond,
  output logic [31:0] header_status,
  output logic event_valid,
  output logic event_error,
  output logic [31:0] event_cause,
  output logic [31:0] event_status,
  output logic [31:0] event_rise,
  output logic [31:0] event_fall,
  output logic error_pin,
  output logic tracking_enable,
  output logic antenna_power,
  output logic rf_enable,
  output logic led_green,
  output logic led_red,
  output logic led_yellow,
  output logic irq
);
  import rsm_pkg::*;

  logic [31:0] error_word_reg;
  logic [31:0] error_word_next;
  logic [31:0] status_reg;
  logic [31:0] status_next;
  logic [31:0] status_prev_reg;
  logic [31:0] prio_mask_reg;
  logic [31:0] set_mask_reg;
  logic [31:0] clear_mask_reg;
  logic [31:0] aux1_reg;
  logic [31:0] aux2_reg;
  logic [31:0] aux3_reg;
  logic [31:0] aux1_prio_reg;
  logic [31:0] aux2_prio_reg;
  logic [31:0] aux3_prio_reg;
  logic event_en_reg;
  logic error_state_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0] prio_hit;
  logic [31:0] rise_hit;
  logic [31:0] fall_hit;
  logic error_cause;
  logic error_entry;
  logic [CODE_W-1:0] code_next;
  logic [CODE_W-1:0] code_reg;
  logic quarter_tick;
  logic [63:0] cause_vec;

  ////////////////////////////////////////////////////////////////////////////
  // Error word and status word assembly.

  // Cause bits stick once seen so the cause survives the condition going away.
  assign error_word_next = error_word_reg | fatal_cond;

  // Bit 0 flags an error, bits 31..29 summarise the masked auxiliary words.
  always_comb begin
    status_next = status_cond;
    status_next[STAT_ERROR_BIT] = |error_word_next;
    status_next[STAT_AUX1_BIT] = |(aux1_cond & aux1_prio_reg);
    status_next[STAT_AUX2_BIT] = |(aux2_cond & aux2_prio_reg);
    status_next[STAT_AUX3_BIT] = |(aux3_cond & aux3_prio_reg);
  end

  // Sample all condition words every cycle.
  always_ff @(posedge clock) begin
    if (reset) begin
      error_word_reg <= 32'h0000_0000;
      status_reg <= 32'h0000_0000;
      status_prev_reg <= 32'h0000_0000;
      aux1_reg <= 32'h0000_0000;
      aux2_reg <= 32'h0000_0000;
      aux3_reg <= 32'h0000_0000;
      header_status <= 32'h0000_0000;
    end else begin
      error_word_reg <= error_word_next;
      status_reg <= status_next;
      status_prev_reg <= status_reg;
      aux1_reg <= aux1_cond;
      aux2_reg <= aux2_cond;
      aux3_reg <= aux3_cond;
      header_status <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error latch and shutdown outputs.

  assign prio_hit = status_reg & prio_mask_reg;
  assign error_cause = (|error_word_reg) || (|prio_hit);
  assign error_entry = error_cause && !error_state_reg;

  // Only reset releases the latch and the shutdown it causes.
  always_ff @(posedge clock) begin
    if (reset) begin
      error_state_reg <= 1'b0;
      error_pin <= 1'b0;
      tracking_enable <= 1'b1;
      antenna_power <= 1'b1;
      rf_enable <= 1'b1;
    end else if (error_cause) begin
      error_state_reg <= 1'b1;
      error_pin <= 1'b1;
      tracking_enable <= 1'b0;
      antenna_power <= 1'b0;
      rf_enable <= 1'b0;
    end
  end

  // Promoted status bits rank behind every native error bit.
  assign cause_vec = {prio_hit, error_word_reg};

  // Code is the lowest active cause: error bits 0..31, promoted status 32..63.
  always_comb begin
    code_next = code_reg;
    for (int i = 63; i >= 0; i--) begin
      if (cause_vec[i]) begin
        code_next = CODE_W'(i);
      end
    end
  end

  // Track the code so the indicator follows the most important cause.
  always_ff @(posedge clock) begin
    if (reset) begin
      code_reg <= '0;
    end else begin
      code_reg <= code_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event messages.

  assign rise_hit = status_reg & ~status_prev_reg & set_mask_reg;
  assign fall_hit = ~status_reg & status_prev_reg & clear_mask_reg;

  // One-cycle event pulse; the enable gates every kind, error ones included.
  always_ff @(posedge clock) begin
    if (reset) begin
      event_valid <= 1'b0;
      event_error <= 1'b0;
      event_cause <= 32'h0000_0000;
      event_status <= 32'h0000_0000;
      event_rise <= 32'h0000_0000;
      event_fall <= 32'h0000_0000;
    end else begin
      event_valid <= event_en_reg && (error_entry || |rise_hit || |fall_hit);
      event_error <= event_en_reg && error_entry;
      event_cause <= error_word_reg;
      event_status <= status_reg;
      event_rise <= rise_hit;
      event_fall <= fall_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky status, cleared by reading, set wins over clear.

  assign irq_set = {|fall_hit, |rise_hit, error_entry};

  // Read clears all bits except those being set in the same cycle.
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_status_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (bus_read && bus_addr == OFS_IRQ_STATUS) begin
        irq_status_reg <= irq_set;
      end else begin
        irq_status_reg <= irq_status_reg | irq_set;
      end
      irq <= |((irq_status_reg | irq_set) & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; configuration stays writable in the error state.
  always_ff @(posedge clock) begin
    if (reset) begin
      prio_mask_reg <= MASK_RESET;
      set_mask_reg <= MASK_RESET;
      clear_mask_reg <= MASK_RESET;
      aux1_prio_reg <= MASK_RESET;
      aux2_prio_reg <= MASK_RESET;
      aux3_prio_reg <= MASK_RESET;
      event_en_reg <= CTRL_EVENT_EN_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
    end else if (bus_write) begin
      if (bus_addr == OFS_PRIO_MASK) begin
        prio_mask_reg <= bus_wdata;
      end else if (bus_addr == OFS_SET_MASK) begin
        set_mask_reg <= bus_wdata;
      end else if (bus_addr == OFS_CLEAR_MASK) begin
        clear_mask_reg <= bus_wdata;
      end else if (bus_addr == OFS_AUX1_PRIO) begin
        aux1_prio_reg <= bus_wdata;
      end else if (bus_addr == OFS_AUX2_PRIO) begin
        aux2_prio_reg <= bus_wdata;
      end else if (bus_addr == OFS_AUX3_PRIO) begin
        aux3_prio_reg <= bus_wdata;
      end else if (bus_addr == OFS_CONTROL) begin
        event_en_reg <= bus_wdata[CTRL_EVENT_EN_BIT];
      end else if (bus_addr == OFS_IRQ_MASK) begin
        irq_mask_reg <= bus_wdata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads: data in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clock) begin
    if (reset || !bus_read) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_addr == OFS_ERROR_WORD) begin
      bus_rdata <= error_word_reg;
    end else if (bus_addr == OFS_STATUS_WORD) begin
      bus_rdata <= status_reg;
    end else if (bus_addr == OFS_PRIO_MASK) begin
      bus_rdata <= prio_mask_reg;
    end else if (bus_addr == OFS_SET_MASK) begin
      bus_rdata <= set_mask_reg;
    end else if (bus_addr == OFS_CLEAR_MASK) begin
      bus_rdata <= clear_mask_reg;
    end else if (bus_addr == OFS_AUX1_STATUS) begin
      bus_rdata <= aux1_reg;
    end else if (bus_addr == OFS_AUX2_STATUS) begin
      bus_rdata <= aux2_reg;
    end else if (bus_addr == OFS_AUX3_STATUS) begin
      bus_rdata <= aux3_reg;
    end else if (bus_addr == OFS_AUX1_PRIO) begin
      bus_rdata <= aux1_prio_reg;
    end else if (bus_addr == OFS_AUX2_PRIO) begin
      bus_rdata <= aux2_prio_reg;
    end else if (bus_addr == OFS_AUX3_PRIO) begin
      bus_rdata <= aux3_prio_reg;
    end else if (bus_addr == OFS_CONTROL) begin
      bus_rdata <= {30'h0, error_state_reg, event_en_reg};
    end else if (bus_addr == OFS_IRQ_STATUS) begin
      bus_rdata <= {29'h0, irq_status_reg};
    end else if (bus_addr == OFS_IRQ_MASK) begin
      bus_rdata <= {29'h0, irq_mask_reg};
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-second tick and status indicator.
  rsm_divider #(
    .DIV_CYC(QUARTER_TICK_CYC)
  ) rsm_divider_inst (
    .clock(clock),
    .reset(reset),
    .tick(quarter_tick)
  );

  rsm_led rsm_led_inst (
    .clock(clock),
    .reset(reset),
    .tick(quarter_tick),
    .error_state(error_state_reg),
    .code(code_reg),
    .led_green(led_green),
    .led_red(led_red),
    .led_yellow(led_yellow)
  );

endmodule : rsm_monitor

// >>> tb/rsm_chk_monitor.sv
// Checker for the receiver status monitor, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
module rsm_chk #(
  parameter int QUARTER_TICK_CYC = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [rsm_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [rsm_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  input wire logic [rsm_pkg::DATA_W-1:0] bus_rdata,
  input wire logic [31:0] fatal_cond,
  input wire logic [31:0] aux1_cond,
  input wire logic [31:0] header_status,
  input wire logic event_valid,
  input wire logic event_error,
  input wire logic [31:0] event_cause,
  input wire logic [31:0] event_rise,
  input wire logic [31:0] event_fall,
  input wire logic error_pin,
  input wire logic tracking_enable,
  input wire logic antenna_power,
  input wire logic rf_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import rsm_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic [31:0] prio_reg, setm_reg, clrm_reg, aux1p_reg, hs_reg, rise_reg, fall_reg;
  logic en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow copies of the priority, set, clear and aux1 masks and the event enable.
  always_ff @(posedge clock) begin
    if (reset) begin
      {prio_reg, setm_reg, clrm_reg, aux1p_reg} <= '0;
      en_reg <= CTRL_EVENT_EN_RESET;
    end else if (bus_write) begin
      case (bus_addr)
        OFS_PRIO_MASK: prio_reg <= bus_wdata;
        OFS_SET_MASK: setm_reg <= bus_wdata;
        OFS_CLEAR_MASK: clrm_reg <= bus_wdata;
        OFS_AUX1_PRIO: aux1p_reg <= bus_wdata;
        OFS_CONTROL: en_reg <= bus_wdata[CTRL_EVENT_EN_BIT];
        default: ;
      endcase
    end
  end

  // Masked edges of the status word, aligned with the event pulse.
  always_ff @(posedge clock) begin
    if (reset) begin
      {hs_reg, rise_reg, fall_reg} <= '0;
    end else begin
      hs_reg <= header_status;
      rise_reg <= header_status & ~hs_reg & setm_reg;
      fall_reg <= ~header_status & hs_reg & clrm_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_pin_persist: assert property (error_pin |=> error_pin)
    else $error("error pin dropped without reset");
  a_shutdown_tie: assert property (tracking_enable == !error_pin &&
    antenna_power == !error_pin && rf_enable == !error_pin)
    else $error("shutdown outputs disagree with error pin");
  a_fatal_entry: assert property (fatal_cond != '0 |=>
    header_status[STAT_ERROR_BIT] ##1 error_pin)
    else $error("fatal condition did not enter error state");
  a_prio_promote: assert property ((header_status & prio_reg) != '0 |=> error_pin)
    else $error("promoted status bit did not enter error state");
  a_aux_summary: assert property ((aux1_cond & aux1p_reg) != '0 |=>
    header_status[STAT_AUX1_BIT])
    else $error("auxiliary summary bit not set");
  a_error_event: assert property ($rose(error_pin) && en_reg |->
    event_valid && event_error && event_cause != '0)
    else $error("no event on error entry");
  a_events_off: assert property (!en_reg && !$past(en_reg) && !$past(en_reg, 2) |->
    !event_valid)
    else $error("event emitted while disabled");
  a_rise_event: assert property (rise_reg != '0 && en_reg |->
    event_valid && event_rise == rise_reg)
    else $error("rising status event missing");
  a_fall_event: assert property (fall_reg != '0 && en_reg |->
    event_valid && event_fall == fall_reg)
    else $error("falling status event missing");
  a_rdata_idle: assert property (!$past(bus_read) |-> bus_rdata == '0)
    else $error("read data outside its cycle");

  // Main scenarios.
  c_error: cover property ($rose(error_pin));
  c_rise: cover property (event_valid && event_rise != '0);
  c_fall: cover property (event_valid && event_fall != '0);
endmodule : rsm_chk

bind rsm_monitor rsm_chk #(.QUARTER_TICK_CYC(QUARTER_TICK_CYC)) rsm_chk_inst (.clock, .reset,
  .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata, .fatal_cond, .aux1_cond,
  .header_status, .event_valid, .event_error, .event_cause, .event_rise, .event_fall,
  .error_pin, .tracking_enable, .antenna_power, .rf_enable);

// >>> tb/rsm_host_model.sv
// External host that watches the error pin and counts its rising edges.
// Assumes it shares the system clock and reset.
module rsm_host_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic error_pin,
  output logic [7:0] host_rises
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin_q;

  // Count each low-to-high step of the pin.
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_q <= 1'b0;
      host_rises <= 8'h0;
    end else begin
      pin_q <= error_pin;
      if (error_pin && !pin_q) host_rises <= host_rises + 8'h1;
    end
  end
endmodule : rsm_host_model

// >>> tb/rsm_monitor_tb.sv
// Bench for the receiver status monitor: register tasks and scenarios.
// Assumes a 4 ns clock and a quarter tick shortened to 4 cycles.
module rsm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rsm_pkg::*;
  logic clock = 1'b0, reset = 1'b1, bus_write = 1'b0, bus_read = 1'b0;
  logic [7:0] bus_addr = 8'h0, host_rises;
  logic [31:0] bus_wdata = '0, fatal_cond = '0, status_cond = '0;
  logic [31:0] aux1_cond = '0, aux2_cond = '0, aux3_cond = '0;
  logic [31:0] bus_rdata, header_status, event_cause, event_status, event_rise, event_fall;
  logic event_valid, event_error, error_pin, tracking_enable, antenna_power, rf_enable;
  logic led_green, led_red, led_yellow, irq, g, ev_e;
  logic [31:0] rv, ev_r, ev_f, ev_c, ev_s;
  logic [12:0] col;
  int bad_count = 0, cmp_count = 0, k, n, j, now_cyc = 0;
  int t[13];

  // Clock and a free cycle count for the indicator timing.
  always #2 clock = ~clock;
  always @(posedge clock) now_cyc++;

  rsm_monitor #(.QUARTER_TICK_CYC(4)) rsm_monitor_inst (.clock, .reset, .bus_addr, .bus_wdata,
    .bus_write, .bus_read, .bus_rdata, .fatal_cond, .status_cond, .aux1_cond, .aux2_cond,
    .aux3_cond, .header_status, .event_valid, .event_error, .event_cause, .event_status,
    .event_rise, .event_fall, .error_pin, .tracking_enable, .antenna_power, .rf_enable,
    .led_green, .led_red, .led_yellow, .irq);
  rsm_host_model rsm_host_model_inst (.clock, .reset, .error_pin, .host_rises);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    #1 d = bus_rdata;
  endtask : rd

  // Counts event pulses over n cycles and keeps the last one's fields.
  task automatic watch(input int cycles);
    k = 0;
    repeat (cycles) begin
      @(posedge clock);
      #1;
      if (event_valid === 1'b1) begin
        k++;
        {ev_r, ev_f, ev_c, ev_s, ev_e} =
          {event_rise, event_fall, event_cause, event_status, event_error};
      end
    end
  endtask : watch

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Cuts a hang short well after the expected run of about 320 cycles.
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(OFS_CONTROL, rv); chk("control", rv, 32'h1);
    rd(OFS_PRIO_MASK, rv); chk("prio mask", rv, MASK_RESET);
    rd(OFS_IRQ_MASK, rv); chk("irq mask", rv, 32'h0);
    wr(OFS_ERROR_WORD, 32'hFFFF_FFFF);
    rd(OFS_ERROR_WORD, rv); chk("error word", rv, 32'h0);
    rd(8'hFC, rv); chk("unmapped", rv, 32'h0);
    chk("pins", 32'({error_pin, tracking_enable, rf_enable}), 32'h3);
    // Healthy blink: a green toggle every eight cycles gives five in forty.
    n = 0;
    g = led_green;
    repeat (40) begin
      @(posedge clock);
      #1;
      if (led_green !== g) n++;
      g = led_green;
    end
    chk("green toggles", n, 5);
    chk("red yellow", 32'({led_red, led_yellow}), 32'h0);
    // Rise and fall events on status bit 5, with interrupts.
    wr(OFS_SET_MASK, 32'h20);
    wr(OFS_CLEAR_MASK, 32'h20);
    wr(OFS_IRQ_MASK, 32'h7);
    @(posedge clock) status_cond <= 32'h20;
    watch(6); chk("rise count", k, 1); chk("rise bits", ev_r, 32'h20);
    chk("rise status", ev_s, 32'h20);
    chk("status set", header_status, 32'h20); chk("pin", error_pin, 1'b0);
    @(posedge clock) status_cond <= 32'h0;
    watch(6); chk("fall count", k, 1); chk("fall bits", ev_f, 32'h20);
    chk("status clear", header_status, 32'h0);
    chk("irq high", irq, 1'b1);
    rd(OFS_IRQ_STATUS, rv); chk("irq status", rv, 32'h6);
    rd(OFS_IRQ_STATUS, rv); chk("irq cleared", rv, 32'h0);
    watch(3); chk("irq low", irq, 1'b0);
    // Events switched off.
    wr(OFS_CONTROL, 32'h0);
    @(posedge clock) status_cond <= 32'h20;
    watch(6); chk("events off", k, 0);
    @(posedge clock) status_cond <= 32'h0;
    // Auxiliary summaries; the unmasked aux2 bit must not count.
    wr(OFS_AUX1_PRIO, 32'h4);
    wr(OFS_AUX2_PRIO, 32'h4);
    wr(OFS_AUX3_PRIO, 32'h4);
    @(posedge clock) {aux1_cond, aux2_cond} <= {32'h4, 32'h8};
    watch(3); chk("aux summary a", header_status, 32'h8000_0000);
    @(posedge clock) {aux2_cond, aux3_cond} <= {32'h4, 32'h4};
    watch(3); chk("aux summary b", header_status, 32'hE000_0000);
    chk("aux no error", error_pin, 1'b0);
    rd(OFS_AUX2_STATUS, rv); chk("aux2 word", rv, 32'h4);
    rd(OFS_STATUS_WORD, rv); chk("status word", rv, 32'hE000_0000);
    @(posedge clock) {aux1_cond, aux2_cond, aux3_cond} <= '0;
    // Promoted status bit with events still off.
    wr(OFS_PRIO_MASK, 32'h80);
    @(posedge clock) status_cond <= 32'h80;
    watch(6); chk("no error event", k, 0);
    chk("promoted pin", error_pin, 1'b1); chk("host rises", host_rises, 8'h1);
    chk("shutdown", 32'({tracking_enable, antenna_power, rf_enable}), 32'h0);
    rd(OFS_ERROR_WORD, rv); chk("native word", rv, 32'h0);
    // The masked edges of bit 5 set their sticky bits while events were off.
    rd(OFS_IRQ_STATUS, rv); chk("irq error", rv, 32'h7);
    // Reset in mid-run ends the error state.
    @(posedge clock) {status_cond, reset} <= {32'h0, 1'b1};
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    watch(1); chk("pin after reset", error_pin, 1'b0);
    // Fatal bit 31 with events on again.
    @(posedge clock) fatal_cond <= 32'h8000_0000;
    watch(6); chk("error event", k, 1); chk("cause", ev_c, 32'h8000_0000);
    chk("error flag", ev_e, 1'b1); chk("status bit0", header_status, 32'h1);
    chk("error event status", ev_s, 32'h1);
    // Indicator code for cause 31: yellow then five red, then the pause.
    for (int i = 0; i < 13; i++) begin
      n = 0;
      while (led_red !== 1'b1 && led_yellow !== 1'b1 && n < 100) begin
        @(posedge clock);
        #1 n++;
      end
      t[i] = now_cyc;
      col[i] = led_red;
      while ((led_red === 1'b1 || led_yellow === 1'b1) && n < 200) begin
        @(posedge clock);
        #1 n++;
      end
    end
    j = 0;
    for (int i = 7; i > 0; i--) if (t[i] - t[i - 1] == 28) j = i;
    chk("pause found", j != 0, 1'b1);
    for (int m = 0; m < 6; m++) begin
      chk("flash colour", col[j + m], 1'((6'h1F >> (5 - m)) & 6'h1));
      if (m > 0) chk("flash gap", t[j + m] - t[j + m - 1], 12);
    end
    chk("green off", led_green, 1'b0);
    @(posedge clock) fatal_cond <= 32'h0;
    watch(5); chk("pin held", error_pin, 1'b1);
    rd(OFS_ERROR_WORD, rv); chk("sticky cause", rv, 32'h8000_0000);
    rd(OFS_CONTROL, rv); chk("control error", rv, 32'h3);
    complete_run();
  end
endmodule : rsm_monitor_tb
